// file: frame_seq_pkg.sv
package frame_seq_pkg;
	localparam int DATA_W = 32;
	localparam int LEVEL_W = 5;
	localparam int STORAGE_W = 16;
	localparam logic [DATA_W-1:0] DWORD_BYTES = 32'h0000_0004;
	localparam logic [DATA_W-1:0] FRAME_BASE_RESET = 32'h0000_0000;
	localparam logic [DATA_W-1:0] STACK_TOP_RESET = 32'h0000_0000;
	localparam logic [LEVEL_W-1:0] LEVEL_ONE = 5'h01;
	localparam logic [LEVEL_W-1:0] LEVEL_ZERO = 5'h00;
	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_PUSH_BASE = 8'h02,
		ST_READ_DISP = 8'h04,
		ST_PUSH_DISP = 8'h08,
		ST_PUSH_FRAME = 8'h10,
		ST_ALLOC = 8'h20,
		ST_REL_COPY = 8'h40,
		ST_REL_POP = 8'h80
	} seq_state_type;
	typedef enum logic [2:0] {
		ACC_IDLE = 3'h1,
		ACC_BUSY = 3'h2,
		ACC_DONE = 3'h4
	} acc_state_type;
endpackage

// file: frame_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
module frame_sequencer
	import frame_seq_pkg::*;
(
	input wire logic clk_i, // Core clock, 100 MHz.
	input wire logic rst_i, // Synchronous reset, active high.
	input wire logic create_i, // Start frame create, taken when idle.
	input wire logic [STORAGE_W-1:0] storage_i, // Dynamic storage in bytes.
	input wire logic [LEVEL_W-1:0] level_i, // Lexical nesting level.
	input wire logic release_i, // Start frame release, taken when idle.
	input wire logic load_i, // Load both pointer registers, taken when idle.
	input wire logic [DATA_W-1:0] load_frame_base_i, // Value for the frame base.
	input wire logic [DATA_W-1:0] load_stack_top_i, // Value for the stack top.
	output logic busy_o, // High while an operation runs.
	output logic done_o, // One-cycle pulse at operation end.
	output logic [DATA_W-1:0] frame_base_o, // Frame base register.
	output logic [DATA_W-1:0] stack_top_o, // Stack top register.
	output logic mem_req_o, // Stack memory request.
	output logic mem_we_o, // Stack memory write enable.
	output logic [DATA_W-1:0] mem_addr_o, // Stack memory byte address.
	output logic [DATA_W-1:0] mem_wdata_o, // Stack memory write data.
	input wire logic mem_ack_i, // Stack memory acknowledge.
	input wire logic [DATA_W-1:0] mem_rdata_i // Stack memory read data.
);
	seq_state_type state_reg, state_next;
	logic [DATA_W-1:0] frame_base_reg, frame_base_next, stack_top_reg, stack_top_next;
	logic [DATA_W-1:0] frame_ptr_reg, frame_ptr_next, copy_reg, copy_next;
	logic [STORAGE_W-1:0] storage_reg, storage_next;
	logic [LEVEL_W-1:0] level_reg, level_next, count_reg, count_next;
	logic done_reg, done_next;
	logic acc_req, acc_write, acc_done;
	logic [DATA_W-1:0] acc_addr, acc_wdata, acc_rdata;

	////////////////////////////////////////////////////////////////////////////
	stack_access u_access (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.req_i(acc_req),
		.write_i(acc_write),
		.addr_i(acc_addr),
		.wdata_i(acc_wdata),
		.done_o(acc_done),
		.rdata_o(acc_rdata),
		.mem_req_o(mem_req_o),
		.mem_we_o(mem_we_o),
		.mem_addr_o(mem_addr_o),
		.mem_wdata_o(mem_wdata_o),
		.mem_ack_i(mem_ack_i),
		.mem_rdata_i(mem_rdata_i)
	);

	////////////////////////////////////////////////////////////////////////////
	// Access request for the current state; pushes address one doubleword below the top.
	always_comb begin
		acc_req = 1'b0;
		acc_write = 1'b1;
		acc_addr = stack_top_reg - DWORD_BYTES;
		acc_wdata = frame_base_reg;
		unique case (state_reg)
			ST_PUSH_BASE: begin
				acc_req = 1'b1;
			end
			ST_READ_DISP: begin
				acc_req = 1'b1;
				acc_write = 1'b0;
				acc_addr = frame_base_reg - DWORD_BYTES;
			end
			ST_PUSH_DISP: begin
				acc_req = 1'b1;
				acc_wdata = copy_reg;
			end
			ST_PUSH_FRAME: begin
				acc_req = 1'b1;
				acc_wdata = frame_ptr_reg;
			end
			ST_REL_POP: begin
				acc_req = 1'b1;
				acc_write = 1'b0;
				acc_addr = stack_top_reg;
			end
			default: begin
				acc_req = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		state_next = state_reg;
		frame_base_next = frame_base_reg;
		stack_top_next = stack_top_reg;
		frame_ptr_next = frame_ptr_reg;
		copy_next = copy_reg;
		storage_next = storage_reg;
		level_next = level_reg;
		count_next = count_reg;
		done_next = 1'b0;
		unique case (state_reg)
			ST_IDLE: begin
				if (create_i) begin
					storage_next = storage_i;
					level_next = level_i;
					state_next = ST_PUSH_BASE;
				end else if (release_i) begin
					state_next = ST_REL_COPY;
				end else if (load_i) begin
					frame_base_next = load_frame_base_i;
					stack_top_next = load_stack_top_i;
				end
			end
			ST_PUSH_BASE: begin
				if (acc_done) begin
					stack_top_next = stack_top_reg - DWORD_BYTES;
					frame_ptr_next = stack_top_reg - DWORD_BYTES;
					count_next = level_reg - LEVEL_ONE;
					if (level_reg == LEVEL_ZERO) begin
						state_next = ST_ALLOC;
					end else if (level_reg == LEVEL_ONE) begin
						state_next = ST_PUSH_FRAME;
					end else begin
						state_next = ST_READ_DISP;
					end
				end
			end
			ST_READ_DISP: begin
				if (acc_done) begin
					frame_base_next = frame_base_reg - DWORD_BYTES;
					copy_next = acc_rdata;
					state_next = ST_PUSH_DISP;
				end
			end
			ST_PUSH_DISP: begin
				if (acc_done) begin
					stack_top_next = stack_top_reg - DWORD_BYTES;
					count_next = count_reg - LEVEL_ONE;
					// Only level minus one caller entries are copied, so a same-level or
					// re-entrant callee never sees the caller's own frame pointer.
					if (count_reg == LEVEL_ONE) begin
						state_next = ST_PUSH_FRAME;
					end else begin
						state_next = ST_READ_DISP;
					end
				end
			end
			ST_PUSH_FRAME: begin
				if (acc_done) begin
					stack_top_next = stack_top_reg - DWORD_BYTES;
					state_next = ST_ALLOC;
				end
			end
			ST_ALLOC: begin
				frame_base_next = frame_ptr_reg;
				stack_top_next = stack_top_reg - {{(DATA_W-STORAGE_W){1'b0}}, storage_reg};
				done_next = 1'b1;
				state_next = ST_IDLE;
			end
			ST_REL_COPY: begin
				stack_top_next = frame_base_reg;
				state_next = ST_REL_POP;
			end
			ST_REL_POP: begin
				if (acc_done) begin
					frame_base_next = acc_rdata;
					stack_top_next = stack_top_reg + DWORD_BYTES;
					done_next = 1'b1;
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= ST_IDLE;
			frame_base_reg <= FRAME_BASE_RESET;
			stack_top_reg <= STACK_TOP_RESET;
			frame_ptr_reg <= '0;
			copy_reg <= '0;
			storage_reg <= '0;
			level_reg <= '0;
			count_reg <= '0;
			done_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			frame_base_reg <= frame_base_next;
			stack_top_reg <= stack_top_next;
			frame_ptr_reg <= frame_ptr_next;
			copy_reg <= copy_next;
			storage_reg <= storage_next;
			level_reg <= level_next;
			count_reg <= count_next;
			done_reg <= done_next;
		end
	end

	assign busy_o = (state_reg != ST_IDLE);
	assign done_o = done_reg;
	assign frame_base_o = frame_base_reg;
	assign stack_top_o = stack_top_reg;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_level_one_skip: assert property (
		state_reg == ST_PUSH_BASE && acc_done && level_reg == LEVEL_ONE |=> state_reg == ST_PUSH_FRAME)
		else $error("level one create did not go straight to the frame pointer push");
	a_first_push_base: assert property (
		state_reg == ST_PUSH_BASE && mem_req_o |-> mem_we_o && mem_wdata_o == frame_base_reg
			&& mem_addr_o == stack_top_reg - DWORD_BYTES)
		else $error("first push does not carry the caller frame base");
	a_frame_push_value: assert property (
		state_reg == ST_PUSH_FRAME && mem_req_o |-> mem_wdata_o == frame_ptr_reg && mem_addr_o == stack_top_reg - DWORD_BYTES)
		else $error("frame pointer push carries a wrong value");
	a_level_zero_form: assert property (
		state_reg == ST_PUSH_BASE && acc_done && level_reg == LEVEL_ZERO |=> state_reg == ST_ALLOC ##1 done_o)
		else $error("level zero create did not allocate directly");
	a_alloc_result: assert property (
		state_reg == ST_ALLOC |=> stack_top_reg == $past(stack_top_reg) - {{(DATA_W-STORAGE_W){1'b0}}, $past(storage_reg)}
			&& frame_base_reg == $past(frame_ptr_reg))
		else $error("allocation left wrong pointers");
	a_push_decrement: assert property (
		(state_reg == ST_PUSH_DISP || state_reg == ST_PUSH_FRAME) && acc_done |=> stack_top_reg == $past(stack_top_reg) - DWORD_BYTES)
		else $error("push did not lower the stack top by four");
	a_release_order: assert property (
		state_reg == ST_REL_COPY |=> stack_top_reg == $past(frame_base_reg) && state_reg == ST_REL_POP)
		else $error("release did not copy frame base first");
	a_pop_restore: assert property (
		state_reg == ST_REL_POP && acc_done |=> frame_base_reg == $past(acc_rdata)
			&& stack_top_reg == $past(stack_top_reg) + DWORD_BYTES && done_o)
		else $error("release pop restored wrong values");
	a_copy_then_push: assert property (
		state_reg == ST_READ_DISP && acc_done |=> state_reg == ST_PUSH_DISP && copy_reg == $past(acc_rdata))
		else $error("display copy not pushed after read");
	a_copy_count_end: assert property (
		state_reg == ST_PUSH_DISP && acc_done && count_reg == LEVEL_ONE |=> state_reg == ST_PUSH_FRAME)
		else $error("display copy did not end with the frame pointer push");

	c_create_level0: cover property (state_reg == ST_PUSH_BASE && acc_done && level_reg == LEVEL_ZERO);
	c_create_nested: cover property (state_reg == ST_PUSH_DISP && acc_done && count_reg == LEVEL_ONE && level_reg > 5'h02);
	c_release: cover property (state_reg == ST_REL_POP && acc_done);
endmodule
`default_nettype wire

// file: nested_stack_frame_sequencer_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module nested_stack_frame_sequencer_tb_top import frame_seq_pkg::*;;
	logic clk_i, rst_i, create_i, release_i, load_i, busy_o, done_o;
	logic mem_req_o, mem_we_o, mem_ack_i;
	logic [STORAGE_W-1:0] storage_i;
	logic [LEVEL_W-1:0] level_i;
	logic [1:0] delay;
	logic [DATA_W-1:0] load_frame_base_i, load_stack_top_i, frame_base_o, stack_top_o;
	logic [DATA_W-1:0] mem_addr_o, mem_wdata_o, mem_rdata_i, efb, est;
	logic [DATA_W-1:0] ref_mem [4096];
	logic [64:0] seen [$];
	logic [64:0] exp_q [$];
	int err_count, compares;
	frame_sequencer i_frame_sequencer (.clk_i(clk_i), .rst_i(rst_i), .create_i(create_i),
		.storage_i(storage_i), .level_i(level_i), .release_i(release_i), .load_i(load_i),
		.load_frame_base_i(load_frame_base_i), .load_stack_top_i(load_stack_top_i), .busy_o(busy_o),
		.done_o(done_o), .frame_base_o(frame_base_o), .stack_top_o(stack_top_o), .mem_req_o(mem_req_o),
		.mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i),
		.mem_rdata_i(mem_rdata_i));
	stack_mem_model i_stack_mem_model (.clk_i(clk_i), .rst_i(rst_i), .delay_i(delay), .mem_req_i(mem_req_o),
		.mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .mem_ack_o(mem_ack_i),
		.mem_rdata_o(mem_rdata_i));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	////////////////////////////////////////////////////////////////////////////
	always @(posedge clk_i) begin
		if (mem_req_o === 1'b1 && mem_ack_i === 1'b1) begin
			seen.push_back({mem_we_o, mem_addr_o, mem_we_o ? mem_wdata_o : mem_rdata_i});
		end
	end
	task automatic cmp(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] want, input string what);
		compares++;
		if (got !== want) begin
			err_count++;
			$display("[ERR] %0t %s got %h want %h", $time, what, got, want);
		end
	endtask
	task automatic push_ref(input logic [DATA_W-1:0] v);
		est -= DWORD_BYTES;
		ref_mem[est[13:2]] = v;
		exp_q.push_back({1'b1, est, v});
	endtask
	// Builds the expected access list and final pointers from the reference state.
	task automatic expect_op(input logic cr, input logic [4:0] lv, input logic [15:0] sz);
		logic [DATA_W-1:0] fp;
		exp_q.delete();
		if (cr) begin
			push_ref(efb);
			fp = est;
			if (lv > 5'h00) begin
				for (int i = 1; i < int'(lv); i++) begin
					efb -= DWORD_BYTES;
					exp_q.push_back({1'b0, efb, ref_mem[efb[13:2]]});
					push_ref(ref_mem[efb[13:2]]);
				end
				push_ref(fp);
			end
			efb = fp;
			est -= {16'h0000, sz};
		end else begin
			est = efb;
			exp_q.push_back({1'b0, est, ref_mem[est[13:2]]});
			efb = ref_mem[est[13:2]];
			est += DWORD_BYTES;
		end
	endtask
	task automatic run_op(input logic cr, input logic [4:0] lv, input logic [15:0] sz);
		int n;
		logic stray;
		n = 0;
		stray = cr && lv >= 5'h02;
		expect_op(cr, lv, sz);
		@(posedge clk_i);
		seen.delete();
		create_i <= cr;
		release_i <= !cr;
		level_i <= lv;
		storage_i <= sz;
		delay <= 2'($urandom_range(3));
		@(posedge clk_i);
		create_i <= 1'b0;
		release_i <= 1'b0;
		@(negedge clk_i);
		cmp(32'(busy_o), 32'h1, "busy while running");
		while (done_o !== 1'b1 && n < 3000) begin
			@(posedge clk_i);
			release_i <= stray && n == 1;
			create_i <= stray && n == 2;
			@(negedge clk_i);
			n++;
		end
		cmp(32'(n < 3000), 32'h1, "no done pulse");
		cmp(32'(busy_o), 32'h0, "busy at done");
		cmp(32'(seen.size()), 32'(exp_q.size()), "access count");
		for (int i = 0; i < seen.size() && i < exp_q.size(); i++) begin
			cmp(32'(seen[i][64]), 32'(exp_q[i][64]), "direction");
			cmp(seen[i][63:32], exp_q[i][63:32], "address");
			cmp(seen[i][31:0], exp_q[i][31:0], "data");
		end
		cmp(frame_base_o, efb, "frame base");
		cmp(stack_top_o, est, "stack top");
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		#400_000;
		err_count++;
		give_verdict();
	end
	initial begin
		logic [4:0] lvl [10] = '{5'h00, 5'h01, 5'h02, 5'h02, 5'h03, 5'h00, 5'h00, 5'h1f, 5'h01, 5'h00};
		logic crt [10] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
		logic [15:0] sz [10] = '{16'h0010, 16'h000c, 16'h0008, 16'h0000, 16'h0004, 16'h0000, 16'h0000, 16'h0020,
			16'hffff, 16'h0000};
		rst_i = 1'b1;
		{create_i, release_i, load_i, delay, storage_i, level_i} = '0;
		load_frame_base_i = 32'h0000_2f00;
		load_stack_top_i = 32'h0000_3000;
		err_count = 0;
		compares = 0;
		for (int i = 0; i < 4096; i++) begin
			ref_mem[i] = 32'hc0de_0000 | 32'(i);
		end
		void'($urandom(54));
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		cmp(frame_base_o, FRAME_BASE_RESET, "reset frame base");
		cmp(stack_top_o, STACK_TOP_RESET, "reset stack top");
		@(posedge clk_i);
		load_i <= 1'b1;
		@(posedge clk_i);
		load_i <= 1'b0;
		efb = load_frame_base_i;
		est = load_stack_top_i;
		for (int i = 0; i < 10; i++) begin
			run_op(crt[i], lvl[i], sz[i]);
		end
		for (int i = 0; i < 24; i++) begin
			run_op($urandom_range(2) != 0, 5'($urandom_range(31)), 16'($urandom_range(63) * 4));
		end
		give_verdict();
	end
endmodule
`default_nettype wire

// file: stack_access.sv
`timescale 1ns/1ns
`default_nettype none
module stack_access
	import frame_seq_pkg::*;
(
	input wire logic clk_i, // Core clock.
	input wire logic rst_i, // Synchronous reset.
	input wire logic req_i, // Access wanted while high.
	input wire logic write_i, // High for a push, low for a read.
	input wire logic [DATA_W-1:0] addr_i, // Byte address of the doubleword.
	input wire logic [DATA_W-1:0] wdata_i, // Doubleword to write.
	output logic done_o, // One-cycle pulse when the access is over.
	output logic [DATA_W-1:0] rdata_o, // Doubleword read.
	output logic mem_req_o, // Memory request, held until acknowledged.
	output logic mem_we_o, // Memory write enable.
	output logic [DATA_W-1:0] mem_addr_o, // Memory byte address.
	output logic [DATA_W-1:0] mem_wdata_o, // Memory write data.
	input wire logic mem_ack_i, // Memory acknowledge pulse.
	input wire logic [DATA_W-1:0] mem_rdata_i // Memory read data, valid with acknowledge.
);
	acc_state_type state_reg, state_next;
	logic [DATA_W-1:0] addr_reg, addr_next, wdata_reg, wdata_next, rdata_reg, rdata_next;
	logic we_reg, we_next;

	always_comb begin
		state_next = state_reg;
		addr_next = addr_reg;
		wdata_next = wdata_reg;
		rdata_next = rdata_reg;
		we_next = we_reg;
		unique case (state_reg)
			ACC_IDLE: begin
				if (req_i) begin
					state_next = ACC_BUSY;
					addr_next = addr_i;
					wdata_next = wdata_i;
					we_next = write_i;
				end
			end
			ACC_BUSY: begin
				if (mem_ack_i) begin
					state_next = ACC_DONE;
					rdata_next = mem_rdata_i;
				end
			end
			ACC_DONE: begin
				state_next = ACC_IDLE;
			end
			default: begin
				state_next = ACC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= ACC_IDLE;
			addr_reg <= '0;
			wdata_reg <= '0;
			rdata_reg <= '0;
			we_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			addr_reg <= addr_next;
			wdata_reg <= wdata_next;
			rdata_reg <= rdata_next;
			we_reg <= we_next;
		end
	end

	assign done_o = (state_reg == ACC_DONE);
	assign rdata_o = rdata_reg;
	assign mem_req_o = (state_reg == ACC_BUSY);
	assign mem_we_o = we_reg;
	assign mem_addr_o = addr_reg;
	assign mem_wdata_o = wdata_reg;
endmodule
`default_nettype wire

// file: stack_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module stack_mem_model
	import frame_seq_pkg::*;
(
	input wire logic clk_i, // Core clock.
	input wire logic rst_i, // Synchronous reset.
	input wire logic [1:0] delay_i, // Wait cycles before acknowledge.
	input wire logic mem_req_i, // Request from the sequencer.
	input wire logic mem_we_i, // Write when high.
	input wire logic [DATA_W-1:0] mem_addr_i, // Byte address.
	input wire logic [DATA_W-1:0] mem_wdata_i, // Write data.
	output logic mem_ack_o, // One-cycle acknowledge.
	output logic [DATA_W-1:0] mem_rdata_o // Read data, valid with acknowledge.
);
	logic [DATA_W-1:0] mem [4096];
	logic [1:0] wait_reg;
	initial begin
		for (int i = 0; i < 4096; i++) begin
			mem[i] = 32'hc0de_0000 | 32'(i);
		end
	end
	// Read data toggles outside the acknowledge cycle so a late sample shows up.
	always @(posedge clk_i) begin
		if (rst_i) begin
			mem_ack_o <= 1'b0;
			wait_reg <= 2'h0;
			mem_rdata_o <= 32'h0;
		end else if (mem_req_i && !mem_ack_o && wait_reg == delay_i) begin
			mem_ack_o <= 1'b1;
			wait_reg <= 2'h0;
			if (mem_we_i) begin
				mem[mem_addr_i[13:2]] <= mem_wdata_i;
			end else begin
				mem_rdata_o <= mem[mem_addr_i[13:2]];
			end
		end else begin
			mem_ack_o <= 1'b0;
			mem_rdata_o <= ~mem_rdata_o;
			if (mem_req_i && !mem_ack_o) begin
				wait_reg <= wait_reg + 2'h1;
			end
		end
	end
endmodule
`default_nettype wire
